/* File: rtl/swr_defs.svh */
// Constants of the supervisor, watchdog and regulator control block.
`ifndef SWR_DEFS_SVH
`define SWR_DEFS_SVH
// Summary of operation
// [R1] Reset output goes low on output undervoltage or watchdog timeout.
// [R2] After voltage recovers, reset stays low a full pulse time, then releases.
// [R3] No strobe edge within the watchdog timeout (280ms fixed) asserts reset.
// [R4] Idle strobe gives a pulse train: low pulse time, high timeout.
// [R5] Once asserted, reset holds a full pulse time ignoring strobe edges.
// [R6] Watchdog counter clears on an in-time strobe edge and on reset.
// [R7] Watchdog counter is stopped while reset is low.
// [R8] Host must toggle the strobe before the timeout since its last edge.
// [R9] Windowed mode: interval shorter than minimum or longer than maximum resets.
// [R10] Pulse time and watchdog timeout are set independently.
// [R11] Enable turns regulator on; low hold keeps it on after enable falls.
// [R12] Held on with enable low, releasing hold switches the regulator off.
// [R13] With hold high, enable is a plain on/off control.
// [R14] Power-fail flag is low while the sensed input is below 1.231V.
// [R15] Pass transistor off above +165 degrees, back on at +145 degrees.
// [R16] Windowed mode: select low high, select high low disables the watchdog.
// [R17] Strobe is synchronised, edges detected, timeouts counted in cycles.
// [R18] Reset is low during power-on reset, then a full pulse time.

// *****************************************************************
// Timing
// *****************************************************************
`define SWR_CLK_MHZ        100
`define SWR_WD_FIXED_MS    280
`define SWR_WD_FIXED_CYC   (`SWR_WD_FIXED_MS * 1000 * `SWR_CLK_MHZ)
`define SWR_CNT_W          32
`define SWR_CNT_ONE        32'h0000_0001
`define SWR_CNT_ZERO       32'h0000_0000

// *****************************************************************
// Synchronised input vector layout
// *****************************************************************
`define SWR_SYNC_W         9
`define SWR_BIT_STROBE     0
`define SWR_BIT_UNDERVOLT  1
`define SWR_BIT_PF_SENSE   2
`define SWR_BIT_ENABLE     3
`define SWR_BIT_HOLD_N     4
`define SWR_BIT_HOT        5
`define SWR_BIT_COOL       6
`define SWR_BIT_WSEL_LO    7
`define SWR_BIT_WSEL_HI    8

// *****************************************************************
// Window select codes {hi, lo} and window ratio shifts
// *****************************************************************
`define SWR_WSEL_R8        2'h0
`define SWR_WSEL_R16       2'h2
`define SWR_WSEL_R64       2'h3
`define SWR_WSEL_OFF       2'h1
`define SWR_SHIFT_R8       3
`define SWR_SHIFT_R16      4
`define SWR_SHIFT_R64      6
`endif

/* File: rtl/swr_pkg.sv */
// Types of the supervisor, watchdog and regulator control block.
`include "swr_defs.svh"
package swr_pkg;

  typedef enum logic [0:0] {
    ST_PULSE = 1'b0,
    ST_RUN   = 1'b1
  } swr_state_type;

  typedef struct packed {
    logic [`SWR_SYNC_W-1:0] s1;
    logic [`SWR_SYNC_W-1:0] s2;
    logic [`SWR_SYNC_W-1:0] s3;
    logic [`SWR_SYNC_W-1:0] q;
  } swr_sync_type;

  typedef struct packed {
    swr_state_type          state;
    logic [`SWR_CNT_W-1:0]  rst_cnt;
    logic [`SWR_CNT_W-1:0]  wd_cnt;
    logic                   strobe_prev;
    logic                   first_seen;
    logic                   reset_n;
    logic                   pf_n;
    logic                   reg_on;
    logic                   thermal_off;
    logic                   reg_out;
  } swr_regs_type;

endpackage

/* File: rtl/swr_sync.sv */
// Three-stage synchroniser with agreement filter for the pin inputs.
`include "swr_defs.svh"
module swr_sync
  import swr_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  wire logic [`SWR_SYNC_W-1:0] pins_in,
  output      logic [`SWR_SYNC_W-1:0] pins_sync
);

  swr_sync_type r;
  swr_sync_type n;

  // *****************************************************************
  // Stage chain
  // *****************************************************************
  // Stage one feeds stage two only; the output follows once stages two
  // and three agree, so a single sampled glitch never reaches the block.
  always_comb begin
    n    = r;
    n.s1 = pins_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.q  = (r.s2 & ~(r.s2 ^ r.s3)) | (r.q & (r.s2 ^ r.s3));
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pins_sync = r.q;

endmodule // swr_sync

/* File: rtl/swr_supervisor.sv */
// Reset supervisor, watchdog and regulator on/off control.
`include "swr_defs.svh"
module swr_supervisor
  import swr_pkg::*;
#(
  parameter logic [`SWR_CNT_W-1:0] WD_FIXED_CYCLES = `SWR_WD_FIXED_CYC
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  watchdog_strobe_in,
  input  wire logic                  undervoltage_in,
  input  wire logic                  power_fail_sense_in,
  input  wire logic                  primary_regulator_on_request,
  input  wire logic                  hold_n_in,
  input  wire logic                  thermal_hot_in,
  input  wire logic                  thermal_cool_in,
  input  wire logic                  window_select_lo,
  input  wire logic                  window_select_hi,
  input  wire logic                  windowed_variant,
  input  wire logic                  use_fixed_watchdog,
  input  wire logic [`SWR_CNT_W-1:0] watchdog_timeout_cycles,
  input  wire logic [`SWR_CNT_W-1:0] reset_pulse_cycles,
  output      logic                  host_reset_n,
  output      logic                  power_fail_flag_n,
  output      logic                  primary_regulator_output
);

  // *****************************************************************
  // Input synchronisation
  // *****************************************************************
  logic [`SWR_SYNC_W-1:0] pins_raw;
  logic [`SWR_SYNC_W-1:0] pins_s;

  assign pins_raw = {window_select_hi, window_select_lo, thermal_cool_in,
                     thermal_hot_in, hold_n_in, primary_regulator_on_request,
                     power_fail_sense_in, undervoltage_in, watchdog_strobe_in};

  swr_sync u_sync (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .pins_in   (pins_raw),
    .pins_sync (pins_s)
  );

  logic       strobe_s;
  logic       uv_s;
  logic       pf_s;
  logic       en_s;
  logic       hold_n_s;
  logic       hot_s;
  logic       cool_s;
  logic [1:0] wsel_s;

  assign strobe_s = pins_s[`SWR_BIT_STROBE]; // R17
  assign uv_s     = pins_s[`SWR_BIT_UNDERVOLT];
  assign pf_s     = pins_s[`SWR_BIT_PF_SENSE];
  assign en_s     = pins_s[`SWR_BIT_ENABLE];
  assign hold_n_s = pins_s[`SWR_BIT_HOLD_N];
  assign hot_s    = pins_s[`SWR_BIT_HOT];
  assign cool_s   = pins_s[`SWR_BIT_COOL];
  assign wsel_s   = {pins_s[`SWR_BIT_WSEL_HI], pins_s[`SWR_BIT_WSEL_LO]};

  // *****************************************************************
  // Durations
  // *****************************************************************
  // A zero length would never expire, so it is read as one cycle.
  logic [`SWR_CNT_W-1:0] rp_len;
  logic [`SWR_CNT_W-1:0] wd_sel;
  logic [`SWR_CNT_W-1:0] wd_max;
  logic [`SWR_CNT_W-1:0] wd_min;
  logic                  wd_en;

  always_comb begin
    rp_len = (reset_pulse_cycles == `SWR_CNT_ZERO) ? `SWR_CNT_ONE
                                                    : reset_pulse_cycles; // R10
    wd_sel = use_fixed_watchdog ? WD_FIXED_CYCLES : watchdog_timeout_cycles;
    wd_max = (wd_sel == `SWR_CNT_ZERO) ? `SWR_CNT_ONE : wd_sel; // R10
    case (wsel_s)
      `SWR_WSEL_R8: begin
        wd_min = wd_max >> `SWR_SHIFT_R8;
      end
      `SWR_WSEL_R16: begin
        wd_min = wd_max >> `SWR_SHIFT_R16;
      end
      `SWR_WSEL_R64: begin
        wd_min = wd_max >> `SWR_SHIFT_R64;
      end
      default: begin
        wd_min = `SWR_CNT_ZERO;
      end
    endcase
    wd_en = !(windowed_variant && (wsel_s == `SWR_WSEL_OFF)); // R16
  end

  // *****************************************************************
  // State
  // *****************************************************************
  swr_regs_type r;
  swr_regs_type n;

  always_comb begin
    logic strobe_edge;
    logic fault;
    strobe_edge   = 1'b0;
    fault         = 1'b0;
    n             = r;
    strobe_edge   = strobe_s ^ r.strobe_prev; // R17
    n.strobe_prev = strobe_s;

    case (r.state)
      ST_PULSE: begin
        // Strobe edges are deliberately dropped here.
        n.wd_cnt     = `SWR_CNT_ZERO; // R5 R7
        n.first_seen = 1'b0;
        n.reset_n    = 1'b0;
        if (uv_s) begin
          n.rst_cnt = `SWR_CNT_ZERO; // R2
        end else if (r.rst_cnt >= rp_len - `SWR_CNT_ONE) begin
          n.state   = ST_RUN; // R2 R18
          n.reset_n = 1'b1;
          n.rst_cnt = `SWR_CNT_ZERO;
        end else begin
          n.rst_cnt = r.rst_cnt + `SWR_CNT_ONE; // R5
        end
      end
      ST_RUN: begin
        if (!wd_en) begin
          n.wd_cnt     = `SWR_CNT_ZERO; // R16
          n.first_seen = 1'b0;
        end else if (strobe_edge) begin
          // The first edge after release has no earlier edge to be
          // too close to, so only later edges can be a fast fault.
          if (windowed_variant && r.first_seen && (r.wd_cnt < wd_min)) begin
            fault = 1'b1; // R9
          end
          n.wd_cnt     = `SWR_CNT_ZERO; // R6
          n.first_seen = 1'b1;
        end else if (r.wd_cnt >= wd_max - `SWR_CNT_ONE) begin
          fault = 1'b1; // R3 R9
        end else begin
          n.wd_cnt = r.wd_cnt + `SWR_CNT_ONE;
        end
        if (uv_s || fault) begin
          n.state      = ST_PULSE; // R1 R4
          n.reset_n    = 1'b0;
          n.wd_cnt     = `SWR_CNT_ZERO; // R6
          n.rst_cnt    = `SWR_CNT_ZERO;
          n.first_seen = 1'b0;
        end
      end
      default: begin
        n.state   = ST_PULSE;
        n.reset_n = 1'b0;
      end
    endcase

    // Power-fail flag follows the comparator indication.
    n.pf_n = pf_s; // R14

    // Enable switches on; a low hold latches the on state until released.
    n.reg_on = en_s | (r.reg_on & ~hold_n_s); // R11 R12 R13

    // Thermal hysteresis between the hot and cool indications.
    if (hot_s) begin
      n.thermal_off = 1'b1; // R15
    end else if (cool_s) begin
      n.thermal_off = 1'b0; // R15
    end
    n.reg_out = n.reg_on & ~n.thermal_off;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0; // R18
    end else begin
      r <= n;
    end
  end

  assign host_reset_n             = r.reset_n;
  assign power_fail_flag_n        = r.pf_n;
  assign primary_regulator_output = r.reg_out;

  // *****************************************************************
  // Checks
  // *****************************************************************
  logic wd_edge_chk;
  assign wd_edge_chk = strobe_s ^ r.strobe_prev;

  AST_UV_RESET: // R1
  assert property (@(posedge ref_clk) disable iff (!resetn)
    uv_s |=> !r.reset_n)
  else $error("Reset not asserted on undervoltage.");

  AST_RELEASE_AFTER_PULSE: // R2
  assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(r.reset_n) |-> ($past(r.rst_cnt) == $past(rp_len) - `SWR_CNT_ONE)
                         && !$past(uv_s))
  else $error("Reset released before a full pulse time.");

  AST_WD_TIMEOUT: // R3
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_RUN && wd_en && !wd_edge_chk && !uv_s
     && r.wd_cnt == wd_max - `SWR_CNT_ONE) |=> !r.reset_n ##1 !r.reset_n)
  else $error("Watchdog timeout did not assert reset.");

  AST_PULSE_HOLD: // R5
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_PULSE && r.rst_cnt < rp_len - `SWR_CNT_ONE)
      |=> !r.reset_n && r.state == ST_PULSE)
  else $error("Reset released during the pulse time.");

  AST_CNT_CLEAR: // R6
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_RUN && wd_en && wd_edge_chk) |=> r.wd_cnt == `SWR_CNT_ZERO)
  else $error("Watchdog counter not cleared by a strobe edge.");

  AST_CNT_STOP: // R7
  assert property (@(posedge ref_clk) disable iff (!resetn)
    !r.reset_n |-> r.wd_cnt == `SWR_CNT_ZERO)
  else $error("Watchdog counter ran while reset was low.");

  AST_FAST_FAULT: // R9
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_RUN && wd_en && windowed_variant && wd_edge_chk
     && r.first_seen && r.wd_cnt < wd_min) |=> !r.reset_n)
  else $error("Fast strobe fault did not assert reset.");

  AST_HOLD_OFF: // R12
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.reg_on && !en_s && hold_n_s) |=> !r.reg_on && !r.reg_out)
  else $error("Regulator stayed on after hold release.");

  AST_PF_FLAG: // R14
  assert property (@(posedge ref_clk) disable iff (!resetn)
    ##1 r.pf_n == $past(pf_s))
  else $error("Power-fail flag does not follow the comparator.");

  AST_THERMAL: // R15
  assert property (@(posedge ref_clk) disable iff (!resetn)
    hot_s |=> !r.reg_out && r.thermal_off)
  else $error("Output on while over temperature.");

  AST_WD_DISABLED: // R16
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (!wd_en && r.state == ST_RUN && !uv_s) |=> r.reset_n)
  else $error("Disabled watchdog asserted reset.");

  AST_SLOW_FAULT: // R9
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_RUN && wd_en && windowed_variant && !wd_edge_chk
     && r.wd_cnt == wd_max - `SWR_CNT_ONE) |=> !r.reset_n)
  else $error("Slow strobe fault did not assert reset.");

  AST_FIRST_EDGE_SAFE: // R9
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_RUN && !r.first_seen && wd_edge_chk && !uv_s) |=> r.reset_n)
  else $error("First strobe edge after release caused a fault.");

  AST_CNT_RESUME: // R7
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_RUN && wd_en && !wd_edge_chk && !uv_s
     && r.wd_cnt < wd_max - `SWR_CNT_ONE) |=> r.wd_cnt == $past(r.wd_cnt) + `SWR_CNT_ONE)
  else $error("Watchdog counter did not count after release.");

  AST_RELEASE_CLEAR: // R7
  assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(r.reset_n) |-> r.state == ST_RUN && r.wd_cnt == `SWR_CNT_ZERO)
  else $error("Watchdog counter not idle at reset release.");

  AST_PULSE_ENTRY: // R6
  assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(r.reset_n) |-> r.state == ST_PULSE && r.wd_cnt == `SWR_CNT_ZERO
                         && r.rst_cnt == `SWR_CNT_ZERO)
  else $error("Watchdog counter not cleared when reset asserted.");

  AST_PULSE_UV: // R2
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.state == ST_PULSE && uv_s) |=> !r.reset_n && r.rst_cnt == `SWR_CNT_ZERO)
  else $error("Pulse time not restarted while undervoltage persists.");

  AST_ENABLE_ON: // R11
  assert property (@(posedge ref_clk) disable iff (!resetn)
    en_s |=> r.reg_on)
  else $error("Regulator not switched on by enable.");

  AST_HOLD_KEEP: // R11
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (r.reg_on && !hold_n_s) |=> r.reg_on)
  else $error("Regulator dropped while hold was low.");

  AST_HOLD_PLAIN: // R13
  assert property (@(posedge ref_clk) disable iff (!resetn)
    hold_n_s |=> r.reg_on == $past(en_s))
  else $error("Enable does not act as plain on/off with hold high.");

  AST_COOL_ON: // R15
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (cool_s && !hot_s) |=> !r.thermal_off)
  else $error("Pass transistor not restored after cooling.");

  AST_PF_LOW: // R14
  assert property (@(posedge ref_clk) disable iff (!resetn)
    !pf_s |=> !r.pf_n)
  else $error("Power-fail flag high while sense is below reference.");

endmodule // swr_supervisor

/* File: tb/swr_host_model.sv */
// Host model that services the watchdog strobe of the supervisor.
module swr_host_model (
  input  wire logic        ref_clk,
  input  wire logic        run,
  input  wire logic        poke,
  input  wire logic [15:0] period,
  input  wire logic        host_reset_n,
  output      logic        watchdog_strobe_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_r;
  initial begin
    watchdog_strobe_in = 1'b0;
    cnt_r = 16'h0000;
  end
  // A host held in reset runs no code, so its service count restarts on release.
  always @(posedge ref_clk) begin
    if (poke) begin
      watchdog_strobe_in <= ~watchdog_strobe_in;
    end else if (!run || !host_reset_n) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r + 16'h0001 >= period) begin
      cnt_r <= 16'h0000;
      watchdog_strobe_in <= ~watchdog_strobe_in;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule // swr_host_model

/* File: tb/swr_testbench.sv */
// Self-checking testbench of the supervisor, watchdog and regulator block.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] T = 32'h0000_0080;
  localparam logic [31:0] P = 32'h0000_000A;
  localparam logic [31:0] F = 32'h0000_00C8;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        uv = 1'b0, pfs = 1'b0, en = 1'b0, hold_n = 1'b1;
  logic        hot = 1'b0, cool = 1'b0, wlo = 1'b0, whi = 1'b0, win = 1'b0;
  logic        run = 1'b1, poke = 1'b0, strobe, rst_n, pf_n, out;
  logic        fix = 1'b0;
  int          failures = 0, samples_checked = 0;

  always #5 ref_clk = ~ref_clk;

  swr_host_model u_host (.ref_clk(ref_clk), .run(run), .poke(poke), .period(16'h0028),
    .host_reset_n(rst_n), .watchdog_strobe_in(strobe));

  swr_supervisor #(.WD_FIXED_CYCLES(F)) u_dut (.ref_clk(ref_clk),
    .resetn(resetn), .watchdog_strobe_in(strobe), .undervoltage_in(uv),
    .power_fail_sense_in(pfs), .primary_regulator_on_request(en), .hold_n_in(hold_n),
    .thermal_hot_in(hot), .thermal_cool_in(cool), .window_select_lo(wlo),
    .window_select_hi(whi), .windowed_variant(win), .use_fixed_watchdog(fix),
    .watchdog_timeout_cycles(T), .reset_pulse_cycles(P), .host_reset_n(rst_n),
    .power_fail_flag_n(pf_n), .primary_regulator_output(out));

  // ********************
  // Shared tasks
  // ********************
  task automatic complete_run;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Bounded so that a reset that never comes still returns a count.
  task automatic wait_for(input logic v, output logic [31:0] n);
    n = 32'h0000_0000;
    while (rst_n !== v && n < 32'h0000_03E8) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic toggle;
    @(posedge ref_clk);
    poke <= 1'b1;
    @(posedge ref_clk);
    poke <= 1'b0;
  endtask
  task automatic restart(input logic w, input logic f, input logic [1:0] code);
    logic [31:0] n;
    @(posedge ref_clk);
    resetn <= 1'b0;
    win <= w;
    fix <= f;
    {whi, wlo} <= code;
    cyc(5);
    chk(rst_n, 1'b0);
    @(posedge ref_clk);
    resetn <= 1'b1;
    wait_for(1'b1, n);
    chk(n >= P && n <= P + 2, 1'b1);
  endtask
  task automatic set_in(input logic e, input logic h, input logic p, input logic [1:0] th);
    @(posedge ref_clk);
    en <= e;
    hold_n <= h;
    pfs <= p;
    {hot, cool} <= th;
    cyc(6);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic s_regulator;
    set_in(1'b1, 1'b1, 1'b1, 2'h0); chk({out, pf_n}, 2'h3);
    set_in(1'b0, 1'b1, 1'b0, 2'h0); chk({out, pf_n}, 2'h0);
    set_in(1'b1, 1'b0, 1'b0, 2'h0); chk(out, 1'b1);
    set_in(1'b0, 1'b0, 1'b0, 2'h0); chk(out, 1'b1);
    set_in(1'b0, 1'b1, 1'b0, 2'h0); chk(out, 1'b0);
    set_in(1'b1, 1'b1, 1'b1, 2'h2); chk(out, 1'b0);
    set_in(1'b1, 1'b1, 1'b1, 2'h0); chk(out, 1'b0);
    set_in(1'b1, 1'b1, 1'b1, 2'h1); chk(out, 1'b1);
  endtask
  task automatic s_undervolt;
    logic [31:0] n;
    @(posedge ref_clk);
    uv <= 1'b1;
    wait_for(1'b0, n);
    // Four edges through the synchroniser, one more through the output register.
    chk(n, 32'h0000_0006);
    cyc(30);
    chk(rst_n, 1'b0);
    @(posedge ref_clk);
    uv <= 1'b0;
    wait_for(1'b1, n);
    chk(n >= P && n <= P + 5, 1'b1);
  endtask
  task automatic s_service;
    logic [31:0] bad;
    bad = 32'h0000_0000;
    repeat (4 * T) begin
      @(negedge ref_clk);
      if (rst_n !== 1'b1) bad++;
    end
    chk(bad, 32'h0000_0000);
  endtask
  task automatic s_idle_train;
    logic [31:0] n;
    @(posedge ref_clk);
    run <= 1'b0;
    wait_for(1'b0, n);
    fork
      wait_for(1'b1, n);
      // A later toggle would reach the synchroniser output after release and count.
      repeat (2) toggle;
    join
    chk(n, P);
    wait_for(1'b0, n);
    chk(n, T);
    wait_for(1'b1, n);
    chk(n, P);
  endtask
  // Gaps allow one cycle for the strobe toggle itself.
  task automatic s_window;
    logic [31:0] n;
    logic [1:0]  code [5] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h1};
    int          gap [5] = '{6, 10, 2, 2, 2};
    logic        flt [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++) begin
      restart(1'b1, 1'b0, code[i]);
      cyc(20);
      toggle;
      cyc(gap[i]);
      toggle;
      wait_for(1'b0, n);
      chk(n < 12, flt[i]);
      if (code[i] == 2'h1) chk(n, 32'h0000_03E8);
      if (!flt[i] && code[i] != 2'h1) chk(n, T + 32'h0000_0006);
    end
  endtask
  // The fixed timeout is picked while reset is held, as a static strap would be.
  task automatic s_fixed;
    logic [31:0] n;
    restart(1'b0, 1'b1, 2'h0);
    wait_for(1'b0, n);
    chk(n, F);
    wait_for(1'b1, n);
    chk(n, P);
  endtask

  initial begin
    restart(1'b0, 1'b0, 2'h0);
    s_regulator;
    s_undervolt;
    s_service;
    s_idle_train;
    s_window;
    s_fixed;
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    complete_run;
  end
endmodule // testbench
